// ==== htc_deadtime.sv ====
// Purpose: Dead-time insertion for one waveform channel
// Assumes: dt_tick is a one-cycle pulse from the dead-time prescaler
// Notes:   Both outputs stay low for dead_len prescaled ticks after each edge
`default_nettype none

module htc_deadtime
   import htc_pkg::*;
(
   input  wire logic                  ref_clk,
   input  wire logic                  rst_b,
   input  wire logic                  dt_tick,
   input  wire logic                  wave,
   input  wire logic [HTC_DEAD_W-1:0] dead_len,
   output var  logic                  out_p,
   output var  logic                  out_n
);
   typedef struct packed {
      logic                  prev;
      logic [HTC_DEAD_W-1:0] cnt;
      logic                  p;
      logic                  n;
   } htc_dt_state_t;

   htc_dt_state_t q;
   htc_dt_state_t d;

   always_comb begin
      d      = q;
      d.prev = wave;
      if (wave != q.prev) begin
         // Break before make: both sides off while the gap runs
         d.cnt = dead_len;
         d.p   = 1'b0;
         d.n   = 1'b0;
      end else if (q.cnt != '0) begin
         if (dt_tick) begin
            d.cnt = q.cnt - 1'b1;
         end
      end else begin
         d.p = wave;
         d.n = ~wave;
      end
   end

   always_ff @(posedge ref_clk) begin
      if (!rst_b) begin
         q <= '0;
      end else begin
         q <= d;
      end
   end

   assign out_p = q.p;
   assign out_n = q.n;
endmodule

`default_nettype wire

// ==== htc_pkg.sv ====
// Purpose: Shared constants for the high-speed timer output control block
// Assumes: 32-bit Avalon-MM register slave, byte addresses
// Notes:   Control registers are 8 bits wide in the low byte lane
`default_nettype none

package htc_pkg;
   // ************************************************************
   // Sizes
   // ************************************************************
   localparam int unsigned HTC_CNT_W   = 10;
   localparam int unsigned HTC_NCH     = 3;
   localparam int unsigned HTC_PRESC_W = 14;
   localparam int unsigned HTC_DT_W    = 3;
   localparam int unsigned HTC_DEAD_W  = 4;

   // ************************************************************
   // Register byte offsets
   // ************************************************************
   localparam logic [5:0] HTC_OFS_CTRL_A  = 6'h00;
   localparam logic [5:0] HTC_OFS_CTRL_B  = 6'h04;
   localparam logic [5:0] HTC_OFS_CTRL_C  = 6'h08;
   localparam logic [5:0] HTC_OFS_CTRL_D  = 6'h0c;
   localparam logic [5:0] HTC_OFS_CMP_A   = 6'h10;
   localparam logic [5:0] HTC_OFS_CMP_B   = 6'h14;
   localparam logic [5:0] HTC_OFS_CMP_TOP = 6'h18;
   localparam logic [5:0] HTC_OFS_CMP_D   = 6'h1c;
   localparam logic [5:0] HTC_OFS_COUNT   = 6'h20;
   localparam logic [5:0] HTC_OFS_STATUS  = 6'h24;

   // ************************************************************
   // Field positions (lsb of each field)
   // ************************************************************
   localparam int unsigned HTC_A_COM_A = 6;
   localparam int unsigned HTC_A_COM_B = 4;
   localparam int unsigned HTC_A_FOC_A = 3;
   localparam int unsigned HTC_A_FOC_B = 2;
   localparam int unsigned HTC_A_PWM_A = 1;
   localparam int unsigned HTC_A_PWM_B = 0;
   localparam int unsigned HTC_B_INV   = 7;
   localparam int unsigned HTC_B_PSR   = 6;
   localparam int unsigned HTC_B_DTPS  = 4;
   localparam int unsigned HTC_B_CS    = 0;
   localparam int unsigned HTC_C_COM_D = 2;
   localparam int unsigned HTC_C_FOC_D = 1;
   localparam int unsigned HTC_C_PWM_D = 0;
   localparam int unsigned HTC_D_WM    = 0;
   localparam int unsigned HTC_D_ASYNC = 2;
   localparam int unsigned HTC_D_DEAD  = 4;

   // ************************************************************
   // Channel indices, reset values, counter bottom and compare output modes
   // ************************************************************
   localparam int unsigned HTC_CH_A = 0;
   localparam int unsigned HTC_CH_B = 1;
   localparam int unsigned HTC_CH_D = 2;
   localparam logic [9:0]  HTC_RST_CMP     = 10'h000;
   localparam logic [9:0]  HTC_RST_TOP     = 10'h3ff;
   localparam logic [9:0]  HTC_BOTTOM      = 10'h000;
   localparam logic [1:0]  HTC_COM_PORT    = 2'h0;
   localparam logic [1:0]  HTC_COM_TOGGLE  = 2'h1;
   localparam logic [1:0]  HTC_COM_CLEAR   = 2'h2;
   localparam logic [1:0]  HTC_COM_SET     = 2'h3;
endpackage

`default_nettype wire

// ==== htc_timer.sv ====
// Purpose: Output control of a 10-bit high-speed timer with three compare channels
// Assumes: Avalon-MM slave with one wait state; pll_clock is an unrelated pin clock
// Notes:   Channel order in vectors is A, B, D
//
// Functional notes
// - Force acts only when channel is non-PWM
// - Force applies compare action, no interrupt
// - Force uses mode written same cycle
// - Force bits always read as zero
// - PWM enable A/B selects PWM operation
// - Inversion flips true and complementary outputs in PWM mode only
// - Prescaler reset self-clears, keeps counter
// - Dead-time prescaler divides by 1,2,4,8
// - Clock select stops or divides source
// - Control C upper bits shadow A/B modes
// - Nonzero D mode overrides port pin
// - D complement only PWM with mode 01
// - Non-PWM D: port, toggle, clear, set
// - Fast PWM D clears/sets at match, bottom
// - Dual-slope D action depends on direction
// - Wave mode picks fast or dual-slope
//
// The address map and the Avalon-MM interface to the registers were decided locally.
`default_nettype none

module htc_timer
   import htc_pkg::*;
(
   input  wire logic                 ref_clk,
   input  wire logic                 rst_b,
   input  wire logic [5:0]           avs_address,
   input  wire logic                 avs_read,
   input  wire logic                 avs_write,
   input  wire logic [31:0]          avs_writedata,
   input  wire logic [3:0]           avs_byteenable,
   output var  logic [31:0]          avs_readdata,
   output var  logic                 avs_waitrequest,
   input  wire logic                 pll_clock,
   input  wire logic [HTC_NCH-1:0]   port_val,
   input  wire logic [HTC_NCH-1:0]   port_val_n,
   output var  logic [HTC_NCH-1:0]   cmp_pin,
   output var  logic [HTC_NCH-1:0]   cmp_pin_n,
   output var  logic [HTC_NCH-1:0]   pin_ovr,
   output var  logic [HTC_NCH-1:0]   pin_ovr_n
);
   // ************************************************************
   // State
   // ************************************************************
   typedef struct packed {
      logic [1:0]                    sync_pll;
      logic                          pll_prev;
      logic [HTC_NCH-1:0][1:0]       com;
      logic [HTC_NCH-1:0]            pwm_en;
      logic                          invert;
      logic [1:0]                    dt_div;
      logic [3:0]                    clk_sel;
      logic [1:0]                    wave_mode;
      logic                          async_sel;
      logic [HTC_DEAD_W-1:0]         dead_len;
      logic [HTC_NCH-1:0][9:0]       cmp;
      logic [9:0]                    top;
      logic [9:0]                    count;
      logic                          count_up;
      logic [HTC_PRESC_W-1:0]        presc;
      logic [HTC_DT_W-1:0]           dt_presc;
      logic                          dt_tick;
      logic [HTC_NCH-1:0]            wave;
      logic [HTC_NCH-1:0]            pin;
      logic [HTC_NCH-1:0]            pin_n;
      logic [HTC_NCH-1:0]            ovr;
      logic [HTC_NCH-1:0]            ovr_n;
      logic                          waitreq;
      logic [31:0]                   rdata;
   } htc_state_t;

   htc_state_t          q;
   htc_state_t          d;
   logic [HTC_NCH-1:0]  dt_p;
   logic [HTC_NCH-1:0]  dt_n;
   logic                wr;
   logic                wr_a;
   logic                wr_b;
   logic                wr_c;

   // Write takes effect on the edge where waitrequest is seen low
   assign wr   = avs_write && !q.waitreq;
   assign wr_a = wr && avs_byteenable[0] && avs_address == HTC_OFS_CTRL_A;
   assign wr_b = wr && avs_byteenable[0] && avs_address == HTC_OFS_CTRL_B;
   assign wr_c = wr && avs_byteenable[0] && avs_address == HTC_OFS_CTRL_C;

   // ************************************************************
   // Compare output action
   // ************************************************************
   function automatic logic htc_act(input logic [1:0] com, input logic pwm, input logic dual,
                                    input logic match, input logic bottom, input logic up,
                                    input logic cur);
      logic r;
      r = cur;
      if (com == HTC_COM_PORT) begin
         r = cur;
      end else if (!pwm) begin
         if (match) begin
            case (com)
               HTC_COM_TOGGLE: r = ~cur;
               HTC_COM_CLEAR:  r = 1'b0;
               default:        r = 1'b1;
            endcase
         end
      end else if (!dual) begin
         if (bottom) begin
            r = (com != HTC_COM_SET);
         end
         if (match) begin
            r = (com == HTC_COM_SET);
         end
      end else if (match) begin
         r = (com == HTC_COM_SET) ? up : ~up;
      end
      return r;
   endfunction

   // ************************************************************
   // Next state
   // ************************************************************
   always_comb begin
      logic                   src;
      logic                   t_tick;
      logic                   dual;
      logic                   dt_tk;
      logic [HTC_PRESC_W-1:0] mask;
      logic [HTC_DT_W-1:0]    dtmask;
      logic [31:0]            rdval;
      logic [HTC_NCH-1:0]     force_ch;
      logic [7:0]             wd;
      src      = 1'b0;
      t_tick   = 1'b0;
      dual     = 1'b0;
      dt_tk    = 1'b0;
      mask     = '0;
      dtmask   = '0;
      rdval    = '0;
      force_ch = '0;
      wd       = avs_writedata[7:0];
      d        = q;

      // Pin clock edge, only the second stage feeds logic
      d.sync_pll = {q.sync_pll[0], pll_clock};
      d.pll_prev = q.sync_pll[1];
      src = q.async_sel ? (q.sync_pll[1] && !q.pll_prev) : 1'b1;

      // Register read mux; force and prescaler-reset bits read zero
      case (avs_address)
         HTC_OFS_CTRL_A:  rdval = {24'h0, q.com[HTC_CH_A], q.com[HTC_CH_B], 2'h0,
                                   q.pwm_en[HTC_CH_A], q.pwm_en[HTC_CH_B]};
         HTC_OFS_CTRL_B:  rdval = {24'h0, q.invert, 1'b0, q.dt_div, q.clk_sel};
         HTC_OFS_CTRL_C:  rdval = {24'h0, q.com[HTC_CH_A], q.com[HTC_CH_B], q.com[HTC_CH_D],
                                   1'b0, q.pwm_en[HTC_CH_D]};
         HTC_OFS_CTRL_D:  rdval = {24'h0, q.dead_len, 1'b0, q.async_sel, q.wave_mode};
         HTC_OFS_CMP_A:   rdval = {22'h0, q.cmp[HTC_CH_A]};
         HTC_OFS_CMP_B:   rdval = {22'h0, q.cmp[HTC_CH_B]};
         HTC_OFS_CMP_TOP: rdval = {22'h0, q.top};
         HTC_OFS_CMP_D:   rdval = {22'h0, q.cmp[HTC_CH_D]};
         HTC_OFS_COUNT:   rdval = {22'h0, q.count};
         HTC_OFS_STATUS:  rdval = {28'h0, q.count_up, q.wave};
         default:         rdval = '0;
      endcase

      // One wait state on every access, mapped or not
      if ((avs_read || avs_write) && q.waitreq) begin
         d.waitreq = 1'b0;
         d.rdata   = avs_read ? rdval : '0;
      end else begin
         d.waitreq = 1'b1;
      end

      // Main prescaler and dead-time prescaler share the source tick
      if (wr_b && wd[HTC_B_PSR]) begin
         d.presc    = '0;
         d.dt_presc = '0;
      end else if (src) begin
         d.presc    = q.presc + 1'b1;
         d.dt_presc = q.dt_presc + 1'b1;
      end
      mask   = HTC_PRESC_W'((15'h1 << (q.clk_sel - 4'h1)) - 15'h1);
      // A tick in the reset cycle would move the counter that the reset must leave alone
      t_tick = src && (q.clk_sel != 4'h0) && ((q.presc & mask) == mask) && !(wr_b && wd[HTC_B_PSR]);
      dtmask = HTC_DT_W'((4'h1 << q.dt_div) - 4'h1);
      dt_tk  = src && ((q.dt_presc & dtmask) == dtmask);
      d.dt_tick = dt_tk;

      // Counter and compare actions
      dual = (|q.pwm_en) && q.wave_mode[0];
      if (t_tick) begin
         for (int i = 0; i < HTC_NCH; i++) begin
            d.wave[i] = htc_act(q.com[i], q.pwm_en[i], dual, q.count == q.cmp[i],
                                q.count == HTC_BOTTOM, q.count_up, q.wave[i]);
         end
         if (q.top == HTC_BOTTOM) begin
            d.count = HTC_BOTTOM;
         end else if (!dual) begin
            d.count = (q.count >= q.top) ? HTC_BOTTOM : q.count + 1'b1;
            d.count_up = 1'b1;
         end else if (q.count_up) begin
            if (q.count >= q.top) begin
               d.count_up = 1'b0;
               d.count    = q.count - 1'b1;
            end else begin
               d.count = q.count + 1'b1;
            end
         end else if (q.count == HTC_BOTTOM) begin
            d.count_up = 1'b1;
            d.count    = q.count + 1'b1;
         end else begin
            d.count = q.count - 1'b1;
         end
      end

      // Register writes
      if (wr_a) begin
         d.com[HTC_CH_A]    = wd[HTC_A_COM_A +: 2];
         d.com[HTC_CH_B]    = wd[HTC_A_COM_B +: 2];
         d.pwm_en[HTC_CH_A] = wd[HTC_A_PWM_A];
         d.pwm_en[HTC_CH_B] = wd[HTC_A_PWM_B];
         force_ch[HTC_CH_A] = wd[HTC_A_FOC_A] && !wd[HTC_A_PWM_A];
         force_ch[HTC_CH_B] = wd[HTC_A_FOC_B] && !wd[HTC_A_PWM_B];
      end
      if (wr_b) begin
         d.invert  = wd[HTC_B_INV];
         d.dt_div  = wd[HTC_B_DTPS +: 2];
         d.clk_sel = wd[HTC_B_CS +: 4];
      end
      if (wr_c) begin
         d.com[HTC_CH_A]    = wd[HTC_A_COM_A +: 2];
         d.com[HTC_CH_B]    = wd[HTC_A_COM_B +: 2];
         d.com[HTC_CH_D]    = wd[HTC_C_COM_D +: 2];
         d.pwm_en[HTC_CH_D] = wd[HTC_C_PWM_D];
         force_ch[HTC_CH_D] = wd[HTC_C_FOC_D] && !wd[HTC_C_PWM_D];
      end
      if (wr && avs_byteenable[0] && avs_address == HTC_OFS_CTRL_D) begin
         d.wave_mode = wd[HTC_D_WM +: 2];
         d.async_sel = wd[HTC_D_ASYNC];
         d.dead_len  = wd[HTC_D_DEAD +: HTC_DEAD_W];
      end
      for (int i = 0; i < 4; i++) begin
         if (wr && avs_address == HTC_OFS_CMP_A + 6'(4 * i)) begin
            if (avs_byteenable[0]) begin
               if (i == 2) d.top[7:0] = wd;
               else d.cmp[(i == 3) ? 2 : i][7:0] = wd;
            end
            if (avs_byteenable[1]) begin
               if (i == 2) d.top[9:8] = avs_writedata[9:8];
               else d.cmp[(i == 3) ? 2 : i][9:8] = avs_writedata[9:8];
            end
         end
      end

      // Forced action uses the mode just written and is a one-cycle event
      for (int i = 0; i < HTC_NCH; i++) begin
         if (force_ch[i]) begin
            d.wave[i] = htc_act(d.com[i], 1'b0, 1'b0, 1'b1, 1'b0, 1'b0, q.wave[i]);
         end
      end

      // Pin muxing; the direction bit of each pin lives outside this block
      for (int i = 0; i < HTC_NCH; i++) begin
         d.ovr[i]   = q.com[i] != HTC_COM_PORT;
         d.ovr_n[i] = q.pwm_en[i] && q.com[i] == HTC_COM_TOGGLE;
         d.pin[i]   = !d.ovr[i] ? port_val[i] :
                      q.pwm_en[i] ? (dt_p[i] ^ q.invert) : q.wave[i];
         d.pin_n[i] = d.ovr_n[i] ? (dt_n[i] ^ q.invert) : port_val_n[i];
      end
   end

   always_ff @(posedge ref_clk) begin
      if (!rst_b) begin
         q         <= '0;
         q.cmp     <= {HTC_NCH{HTC_RST_CMP}};
         q.top     <= HTC_RST_TOP;
         q.count_up <= 1'b1;
         q.waitreq <= 1'b1;
      end else begin
         q <= d;
      end
   end

   // ************************************************************
   // Dead-time generators
   // ************************************************************
   for (genvar g = 0; g < HTC_NCH; g++) begin : g_dt
      htc_deadtime u_dt (
         .ref_clk  (ref_clk),
         .rst_b    (rst_b),
         .dt_tick  (q.dt_tick),
         .wave     (q.wave[g]),
         .dead_len (q.dead_len),
         .out_p    (dt_p[g]),
         .out_n    (dt_n[g])
      );
   end

   assign avs_readdata    = q.rdata;
   assign avs_waitrequest = q.waitreq;
   assign cmp_pin         = q.pin;
   assign cmp_pin_n       = q.pin_n;
   assign pin_ovr         = q.ovr;
   assign pin_ovr_n       = q.ovr_n;

   // ************************************************************
   // Checks
   // ************************************************************
   property p_foc_reads_zero;
      @(posedge ref_clk) disable iff (!rst_b)
      (avs_read && !avs_waitrequest && avs_address == HTC_OFS_CTRL_A) |-> avs_readdata[3:2] == 2'h0;
   endproperty
   a_foc_reads_zero: assert property (p_foc_reads_zero) else $error("force bits read nonzero");

   property p_psr_reads_zero;
      @(posedge ref_clk) disable iff (!rst_b)
      (avs_read && !avs_waitrequest && avs_address == HTC_OFS_CTRL_B) |-> !avs_readdata[6];
   endproperty
   a_psr_reads_zero: assert property (p_psr_reads_zero) else $error("prescaler reset reads one");

   property p_psr_clears;
      @(posedge ref_clk) disable iff (!rst_b)
      (wr_b && avs_writedata[6]) |=> (q.presc == '0) && $stable(q.count);
   endproperty
   a_psr_clears: assert property (p_psr_clears) else $error("prescaler not reset");

   property p_force_blocked;
      @(posedge ref_clk) disable iff (!rst_b)
      (wr_a && avs_writedata[3] && avs_writedata[1] && q.clk_sel == 4'h0) |=> $stable(q.wave[0]);
   endproperty
   a_force_blocked: assert property (p_force_blocked) else $error("force acted in PWM mode");

   property p_force_new_mode;
      @(posedge ref_clk) disable iff (!rst_b)
      (wr_a && avs_writedata[7:6] == 2'h3 && avs_writedata[3] && !avs_writedata[1]) |=> q.wave[0];
   endproperty
   a_force_new_mode: assert property (p_force_new_mode) else $error("force ignored new mode");

   property p_force_toggle_d;
      @(posedge ref_clk) disable iff (!rst_b)
      (wr_c && avs_writedata[3:0] == 4'h6 && q.clk_sel == 4'h0) |=> q.wave[2] != $past(q.wave[2]);
   endproperty
   a_force_toggle_d: assert property (p_force_toggle_d) else $error("channel D did not toggle");

   property p_stopped;
      @(posedge ref_clk) disable iff (!rst_b)
      (q.clk_sel == 4'h0) [*2] |-> $stable(q.count);
   endproperty
   a_stopped: assert property (p_stopped) else $error("counter ran while stopped");

   property p_ovr_d;
      @(posedge ref_clk) disable iff (!rst_b)
      ##1 pin_ovr[2] == ($past(q.com[2]) != 2'h0);
   endproperty
   a_ovr_d: assert property (p_ovr_d) else $error("channel D override wrong");

   property p_ovr_n_d;
      @(posedge ref_clk) disable iff (!rst_b)
      pin_ovr_n[2] == ($past(q.pwm_en[2]) && $past(q.com[2]) == 2'h1);
   endproperty
   a_ovr_n_d: assert property (p_ovr_n_d) else $error("channel D complement connected wrongly");
endmodule

`default_nettype wire

// ==== htc_timer_tb.sv ====
// Purpose: Self-checking bench for the timer output control block
// Assumes: Slave answers by dropping waitrequest for one cycle
// Notes:   PWM is judged by counting pin levels over a window, so
//          expectations carry a tolerance for the unknown phase
`default_nettype none

module htc_timer_tb;
   timeunit 1ns;
   timeprecision 1ps;
   import htc_pkg::*;

   // ************************************************************
   // Signals
   // ************************************************************
   logic               ref_clk        = 1'b0;
   logic               rst_b          = 1'b0;
   logic [5:0]         avs_address    = 6'h00;
   logic               avs_read       = 1'b0;
   logic               avs_write      = 1'b0;
   logic [31:0]        avs_writedata  = 32'h0;
   logic [3:0]         avs_byteenable = 4'hf;
   logic [31:0]        avs_readdata;
   logic               avs_waitrequest;
   logic               pll_clock      = 1'b0;
   logic [HTC_NCH-1:0] port_val       = 3'h5;
   logic [HTC_NCH-1:0] port_val_n     = 3'h2;
   logic [HTC_NCH-1:0] cmp_pin;
   logic [HTC_NCH-1:0] cmp_pin_n;
   logic [HTC_NCH-1:0] pin_ovr;
   logic [HTC_NCH-1:0] pin_ovr_n;
   int                 fail_count     = 0;
   int                 n_compared     = 0;
   int                 hi;
   int                 hn;
   int                 rs;
   logic [31:0]        rd;
   logic [31:0]        v;

   // Force steps: mode, force, pwm enable, expected wave
   localparam logic [1:0] SM [7] = '{2'h3, 2'h2, 2'h1, 2'h1, 2'h3, 2'h3, 2'h0};
   localparam logic       SF [7] = '{1'b1, 1'b1, 1'b1, 1'b1, 1'b1, 1'b0, 1'b0};
   localparam logic       SP [7] = '{1'b0, 1'b0, 1'b0, 1'b0, 1'b1, 1'b0, 1'b0};
   localparam logic       SE [7] = '{1'b1, 1'b0, 1'b1, 1'b0, 1'b0, 1'b0, 1'b0};
   localparam logic [5:0] RA [3] = '{HTC_OFS_CTRL_A, HTC_OFS_CTRL_A, HTC_OFS_CTRL_C};
   localparam int         MP [3] = '{HTC_A_COM_A, HTC_A_COM_B, HTC_C_COM_D};
   localparam int         FP [3] = '{HTC_A_FOC_A, HTC_A_FOC_B, HTC_C_FOC_D};
   localparam int         PP [3] = '{HTC_A_PWM_A, HTC_A_PWM_B, HTC_C_PWM_D};

   always #12.5 ref_clk = ~ref_clk;
   // Pin clock kept slower than the bus clock so no edge is lost
   always #30 pll_clock = ~pll_clock;

   htc_timer dut (
      .ref_clk         (ref_clk),
      .rst_b           (rst_b),
      .avs_address     (avs_address),
      .avs_read        (avs_read),
      .avs_write       (avs_write),
      .avs_writedata   (avs_writedata),
      .avs_byteenable  (avs_byteenable),
      .avs_readdata    (avs_readdata),
      .avs_waitrequest (avs_waitrequest),
      .pll_clock       (pll_clock),
      .port_val        (port_val),
      .port_val_n      (port_val_n),
      .cmp_pin         (cmp_pin),
      .cmp_pin_n       (cmp_pin_n),
      .pin_ovr         (pin_ovr),
      .pin_ovr_n       (pin_ovr_n)
   );

   // ************************************************************
   // Tasks
   // ************************************************************
   task automatic tally_and_finish();
      $display("compared %0d, mismatches %0d", n_compared, fail_count);
      if (fail_count == 0 && n_compared > 0) begin
         $display("RESULT: PASS");
      end else begin
         $display("RESULT: FAIL");
      end
      $finish;
   endtask

   task automatic chk(input logic [31:0] got, input logic [31:0] exp);
      n_compared++;
      if (got !== exp) begin
         fail_count++;
         $display("BAD t=%0t got=%h exp=%h", $time, got, exp);
      end
   endtask

   task automatic near(input int got, input int exp, input int tol);
      n_compared++;
      if (got < exp - tol || got > exp + tol) begin
         fail_count++;
         $display("BAD t=%0t got=%h exp=%h", $time, got, exp);
      end
   endtask

   // A clock edge passes first, so strobes never change twice in one step
   task automatic xfer(input logic wr, input logic [5:0] a, input logic [31:0] wd, output logic [31:0] d);
      int n;
      n = 0;
      @(posedge ref_clk);
      avs_address <= a;
      avs_writedata <= wd;
      avs_read <= ~wr;
      avs_write <= wr;
      @(posedge ref_clk);
      while (avs_waitrequest !== 1'b0 && n < 100) begin
         n++;
         @(posedge ref_clk);
      end
      if (n >= 100) begin
         fail_count++;
         $display("BAD t=%0t got=%h exp=%h", $time, avs_waitrequest, 1'b0);
      end
      d = avs_readdata;
      avs_read <= 1'b0;
      avs_write <= 1'b0;
   endtask

   task automatic wreg(input logic [5:0] a, input logic [31:0] wd);
      logic [31:0] d;
      xfer(1'b1, a, wd, d);
   endtask

   task automatic rchk(input logic [5:0] a, input logic [31:0] e);
      logic [31:0] d;
      xfer(1'b0, a, 32'h0, d);
      chk(d, e);
   endtask

   task automatic meas(input int ch, input int win);
      logic pv;
      hi = 0;
      hn = 0;
      rs = 0;
      pv = cmp_pin[ch];
      repeat (win) begin
         @(posedge ref_clk);
         if (cmp_pin[ch] === 1'b1) hi++;
         if (cmp_pin_n[ch] === 1'b1) hn++;
         if (cmp_pin[ch] === 1'b1 && pv === 1'b0) rs++;
         pv = cmp_pin[ch];
      end
   endtask

   task automatic run(input logic [7:0] a, b, c, d, input int ch, win, ehi, th, ers, ehn);
      logic [1:0] m;
      logic       p;
      m = ch == 2 ? c[3:2] : (ch == 0 ? a[7:6] : a[5:4]);
      p = ch == 2 ? c[0] : (ch == 0 ? a[1] : a[0]);
      wreg(HTC_OFS_CTRL_D, 32'(d));
      wreg(HTC_OFS_CTRL_C, 32'(c));
      wreg(HTC_OFS_CTRL_A, 32'(a));
      wreg(HTC_OFS_CTRL_B, 32'(b));
      // Long enough for the slowest period to settle
      repeat (600) @(posedge ref_clk);
      meas(ch, win);
      near(hi, ehi, th);
      near(rs, ers, ers == 0 ? 0 : 1);
      if (ehn >= 0) near(hn, ehn, th);
      chk(32'(pin_ovr[ch]), 32'(m != 2'h0));
      chk(32'(pin_ovr_n[ch]), 32'(m == 2'h1 && p));
      $display("pwm run ch %0d ctrl %h %h %h %h done", ch, a, b, c, d);
   endtask

   // ************************************************************
   // Tests
   // ************************************************************
   initial begin
      repeat (16) @(posedge ref_clk);
      rst_b <= 1'b1;
      rchk(HTC_OFS_CTRL_B, 32'h0);
      rchk(HTC_OFS_CMP_TOP, 32'h3ff);
      wreg(6'h3c, 32'hff);
      rchk(6'h3c, 32'h0);
      chk(32'(pin_ovr), 32'h0);
      chk(32'(cmp_pin), 32'(port_val));
      $display("reset test done");
      for (int ch = 0; ch < 3; ch++) begin
         for (int s = 0; s < 7; s++) begin
            v = (32'(SM[s]) << MP[ch]) | (32'(SP[s]) << PP[ch]);
            wreg(RA[ch], v | (32'(SF[s]) << FP[ch]));
            rchk(RA[ch], v);
            rchk(HTC_OFS_STATUS, 32'h8 | (32'(SE[s]) << ch));
            chk(32'(pin_ovr[ch]), 32'(SM[s] != 2'h0));
            chk(32'(pin_ovr_n[ch]), 32'h0);
            if (SP[s] == 1'b0) chk(32'(cmp_pin[ch]), 32'(SM[s] != 2'h0 ? SE[s] : port_val[ch]));
         end
         $display("force test ch %0d done", ch);
      end
      wreg(HTC_OFS_CTRL_C, 32'hd0);
      rchk(HTC_OFS_CTRL_A, 32'hd0);
      wreg(HTC_OFS_CTRL_A, 32'h60);
      rchk(HTC_OFS_CTRL_C, 32'h60);
      $display("shadow test done");
      wreg(HTC_OFS_CMP_TOP, 32'h3f);
      wreg(HTC_OFS_CMP_A, 32'h10);
      wreg(HTC_OFS_CMP_B, 32'h10);
      wreg(HTC_OFS_CMP_D, 32'h10);
      run(8'h82, 8'h01, 8'h00, 8'h00, 0, 640, 160, 20, 10, -1);
      run(8'h21, 8'h01, 8'h00, 8'h00, 1, 640, 160, 20, 10, -1);
      run(8'h00, 8'h01, 8'h09, 8'h00, 2, 640, 160, 20, 10, -1);
      run(8'h00, 8'h01, 8'h0d, 8'h00, 2, 640, 480, 20, 10, -1);
      run(8'h00, 8'h01, 8'h05, 8'h00, 2, 640, 160, 20, 10, 480);
      run(8'h00, 8'h81, 8'h05, 8'h00, 2, 640, 480, 20, 10, 160);
      run(8'h00, 8'h01, 8'h09, 8'h01, 2, 1260, 320, 40, 10, -1);
      run(8'h00, 8'h01, 8'h0d, 8'h01, 2, 1260, 940, 40, 10, -1);
      // Window is a whole number of periods for every division, so the phase cannot bias the count
      for (int i = 1; i < 5; i++) run(8'h00, 8'(i), 8'h09, 8'h00, 2, 1536, 384, 64, 24 >> (i - 1), -1);
      run(8'h00, 8'h01, 8'h09, 8'h04, 2, 1280, 320, 48, 8, -1);
      wreg(HTC_OFS_CMP_D, 32'h20);
      for (int k = 0; k < 4; k++) run(8'h00, 8'h01 | 8'(k << 4), 8'h09, 8'h30, 2, 640, 320 - 30 * (1 << k),
                                      10 * (1 << k) + 5, 10, -1);
      run(8'h00, 8'h00, 8'h09, 8'h00, 2, 640, 320, 320, 0, -1);
      // A stopped counter leaves the pin level constant over the window
      chk(32'(hi % 640), 32'h0);
      // Repeated prescaler resets keep a divide-by-16 clock from ever ticking
      wreg(HTC_OFS_CTRL_B, 32'h45);
      xfer(1'b0, HTC_OFS_COUNT, 32'h0, rd);
      repeat (8) wreg(HTC_OFS_CTRL_B, 32'h45);
      rchk(HTC_OFS_CTRL_B, 32'h5);
      rchk(HTC_OFS_COUNT, rd);
      $display("prescaler reset test done");
      tally_and_finish();
   end

   // Tests need about 28000 cycles; nearly three times that means a hang
   initial begin
      repeat (80000) @(posedge ref_clk);
      fail_count++;
      $display("BAD t=%0t got=%h exp=%h", $time, 0, 1);
      tally_and_finish();
   end
endmodule

`default_nettype wire
